// *** rtl/gpio_fault_pkg.sv ***
`default_nettype none

package gpio_fault_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus shape
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PIN_DIR          = 8'h20;
    localparam logic [7:0] IDX_PIN_LEVEL        = 8'h21;
    localparam logic [7:0] IDX_FAULT_SOURCE     = 8'h22;
    localparam logic [7:0] IDX_FAULT_PIN_CONFIG = 8'h23;
    localparam logic [7:0] IDX_CM_BUFFER_CONFIG = 8'h24;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int FSRC_OVERRANGE_BIT = 5;
    localparam int FSRC_INTERNAL_BIT  = 4;
    localparam int FSRC_SERIAL_BIT    = 3;
    localparam int FPIN_OUT_EN_BIT    = 0;
    localparam int FPIN_IN_EN_BIT     = 1;
    localparam int FPIN_IN_STATUS_BIT = 2;
    localparam int CMB_OFF_BIT        = 6;
    localparam int CMB_RATIO_LSB      = 1;
    localparam int CMB_RATIO_W        = 5;
    localparam int CMB_SOURCE_BIT     = 0;
    localparam int FAULT_OUT_PIN      = 7;
    localparam int FAULT_IN_PIN       = 6;

    // Writable bits; everything else is reserved and reads zero, save the fault input status bit
    localparam logic [7:0] FSRC_WMASK = 8'h38;
    localparam logic [7:0] FPIN_WMASK = 8'h03;
    localparam logic [7:0] CMB_WMASK  = 8'h7F;

    // Values after reset
    localparam logic [7:0] PIN_DIR_RESET   = 8'h00;
    localparam logic [7:0] PIN_LEVEL_RESET = 8'h00;
    localparam logic [7:0] FSRC_RESET      = 8'h00;
    localparam logic [7:0] FPIN_RESET      = 8'h00;
    localparam logic [7:0] CMB_RESET       = 8'h00;

    // Fault pin level while a fault is present (active low)
    localparam logic FAULT_PIN_ACTIVE = 1'b0;

    // Ratio numerator over twenty for the half-scale codes
    localparam logic [4:0] RATIO_HALF = 5'h0A;

    ////////////////////////////////////////////////////////////////////////////
    // Grouped signals
    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              pwrite;
        logic [DATA_W-1:0] pwdata;
        logic [3:0]        pstrb;
    } apb_req_s;

    typedef struct packed {
        logic       overrange;
        logic [4:0] internal;
        logic [3:0] serial;
    } fault_src_s;

endpackage

`default_nettype wire

// *** rtl/gpio_and_fault_pin_control.sv ***
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module gpio_and_fault_pin_control #(
    parameter int PIN_N = 8
) (
    input  wire logic                           i_clk,
    input  wire logic                           i_reset,
    input  wire logic                           i_psel,
    input  wire logic                           i_penable,
    input  wire gpio_fault_pkg::apb_req_s       i_apb_req,
    output logic                                o_pready,
    output logic                                o_pslverr,
    output logic [gpio_fault_pkg::DATA_W-1:0]   o_prdata,
    input  wire logic [PIN_N-1:0]               i_pin_in,
    output logic [PIN_N-1:0]                    o_pin_out,
    output logic [PIN_N-1:0]                    o_pin_oe,
    input  wire gpio_fault_pkg::fault_src_s     i_fault_src,
    output logic                                o_fault_active,
    output logic                                o_midlevel_buffer_off,
    output logic [gpio_fault_pkg::CMB_RATIO_W-1:0] o_midlevel_ratio_sel,
    output logic                                o_midlevel_source_sel,
    output logic [4:0]                          o_midlevel_numerator
);
    import gpio_fault_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte address of a register index
    // One aligned word per register, so a hit has zero low bits
    function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        reg_addr = {2'h0, idx, 2'h0};
    endfunction

    // Numerator over twenty for a ratio code; unlisted codes fall back to half
    // Codes 2 to 10 count down from nineteen, 11 to 19 from nine, so
    // ten over twenty comes only from the half-scale codes
    // Half scale for reserved codes keeps the buffer at a safe level
    function automatic logic [4:0] ratio_num(input logic [4:0] code);
        logic [4:0] num;
        num = RATIO_HALF;
        if (code >= 5'h02 && code <= 5'h0A) begin
            num = 5'h15 - code;
        end else if (code >= 5'h0B && code <= 5'h13) begin
            num = 5'h14 - code;
        end
        ratio_num = num;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers and internal signals
    // Software-visible registers first
    logic [REG_W-1:0]  pin_dir_reg;
    logic [REG_W-1:0]  pin_level_reg;
    logic [REG_W-1:0]  fault_source_reg;
    logic [REG_W-1:0]  fault_pin_reg;
    logic [REG_W-1:0]  cm_buffer_reg;

    // Pin capture and fault status
    logic [PIN_N-1:0]  pin_meta_reg;
    logic [PIN_N-1:0]  pin_sync_reg;
    logic              fault_in_latch_reg;

    // Output flops
    logic [DATA_W-1:0] prdata_reg;
    logic [PIN_N-1:0]  pin_out_reg;
    logic [PIN_N-1:0]  pin_oe_reg;
    logic              fault_active_reg;

    // Bus decode
    logic              setup_phase;
    logic              access_done;
    logic              wr_done;
    logic              rd_done;
    logic              byte0_en;
    logic              addr_hit;
    logic              sel_dir;
    logic              sel_level;
    logic              sel_fsrc;
    logic              sel_fpin;
    logic              sel_cmb;

    // Fault routing
    logic              fault_out_en;
    logic              fault_in_en;
    logic              fault_in_level;
    logic              fault_next;

    // Read mux
    logic [REG_W-1:0]  level_view;
    logic [REG_W-1:0]  rd_value;

    ////////////////////////////////////////////////////////////////////////////
    // Bus phase decode; zero wait states, so every access ends in one cycle
    // Register bits sit in byte lane 0; a write without that strobe
    // is dropped whole rather than half applied
    assign setup_phase = i_psel & ~i_penable;
    assign access_done = i_psel & i_penable;
    assign wr_done     = access_done & i_apb_req.pwrite & byte0_en & addr_hit;
    assign rd_done     = access_done & ~i_apb_req.pwrite & addr_hit;
    assign byte0_en    = i_apb_req.pstrb[0];
    assign o_pready    = 1'b1;
    // Unmapped addresses answer with an error and read zero
    assign o_pslverr   = access_done & ~addr_hit;

    // Address decode
    // Full compare, so aliases of a register answer with an error
    always_comb begin
        sel_dir   = 1'b0;
        sel_level = 1'b0;
        sel_fsrc  = 1'b0;
        sel_fpin  = 1'b0;
        sel_cmb   = 1'b0;
        if (i_apb_req.paddr == reg_addr(IDX_PIN_DIR)) begin
            sel_dir = 1'b1;
        end else if (i_apb_req.paddr == reg_addr(IDX_PIN_LEVEL)) begin
            sel_level = 1'b1;
        end else if (i_apb_req.paddr == reg_addr(IDX_FAULT_SOURCE)) begin
            sel_fsrc = 1'b1;
        end else if (i_apb_req.paddr == reg_addr(IDX_FAULT_PIN_CONFIG)) begin
            sel_fpin = 1'b1;
        end else if (i_apb_req.paddr == reg_addr(IDX_CM_BUFFER_CONFIG)) begin
            sel_cmb = 1'b1;
        end
    end
    assign addr_hit = sel_dir | sel_level | sel_fsrc | sel_fpin | sel_cmb;

    ////////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser; pins come from outside the clock domain
    // Only the second stage is read; the first may be metastable
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= i_pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Fault function overrides the direction bits of pins 6 and 7
    // An upstream pulse shorter than one clock may be missed
    assign fault_out_en   = fault_pin_reg[FPIN_OUT_EN_BIT];
    assign fault_in_en    = fault_pin_reg[FPIN_IN_EN_BIT];
    assign fault_in_level = fault_in_en & pin_sync_reg[FAULT_IN_PIN];

    ////////////////////////////////////////////////////////////////////////////
    // Direction register
    // Zero is input, so every pin floats after reset
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pin_dir_reg <= PIN_DIR_RESET;
        end else if (wr_done && sel_dir) begin
            pin_dir_reg <= i_apb_req.pwdata[REG_W-1:0];
        end
    end

    // Level register; only bits of output pins take a write
    // Input bits keep their last value, which reappears on the pin
    // once it is turned into an output again
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pin_level_reg <= PIN_LEVEL_RESET;
        end else if (wr_done && sel_level) begin
            pin_level_reg <= (i_apb_req.pwdata[REG_W-1:0] & pin_dir_reg)
                           | (pin_level_reg & ~pin_dir_reg);
        end
    end

    // Fault source select
    // Reserved bits are masked on the way in so they read zero
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            fault_source_reg <= FSRC_RESET;
        end else if (wr_done && sel_fsrc) begin
            fault_source_reg <= i_apb_req.pwdata[REG_W-1:0] & FSRC_WMASK;
        end
    end

    // Fault pin configuration; status bit is not stored here
    // It is read from the latch below instead
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            fault_pin_reg <= FPIN_RESET;
        end else if (wr_done && sel_fpin) begin
            fault_pin_reg <= i_apb_req.pwdata[REG_W-1:0] & FPIN_WMASK;
        end
    end

    // Mid-level buffer configuration
    // Bit 7 is reserved and masked off
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cm_buffer_reg <= CMB_RESET;
        end else if (wr_done && sel_cmb) begin
            cm_buffer_reg <= i_apb_req.pwdata[REG_W-1:0] & CMB_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault input latch; a read of the fault pin register clears it, but a
    // fault seen in the same cycle wins; one seen only in the setup phase is cleared without being read
    // Turning the input off clears it too, so no stale event shows
    // when the input is enabled again
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            fault_in_latch_reg <= 1'b0;
        end else if (fault_in_level) begin
            fault_in_latch_reg <= 1'b1;
        end else if (!fault_in_en || (rd_done && sel_fpin)) begin
            fault_in_latch_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault combine; diagnostic enables live outside, so a source
    // that is not enabled there simply never rises here
    // Pin 6 feeds in whatever the source enables say
    always_comb begin
        fault_next = 1'b0;
        if (fault_source_reg[FSRC_OVERRANGE_BIT] && i_fault_src.overrange) begin
            fault_next = 1'b1;
        end
        if (fault_source_reg[FSRC_INTERNAL_BIT] && (|i_fault_src.internal)) begin
            fault_next = 1'b1;
        end
        if (fault_source_reg[FSRC_SERIAL_BIT] && (|i_fault_src.serial)) begin
            fault_next = 1'b1;
        end
        if (fault_in_level) begin
            fault_next = 1'b1;
        end
    end

    // Registered fault state for the pin and the status port
    // One decision feeds both, so pin 7 and the status never
    // disagree, at the cost of one cycle of latency
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            fault_active_reg <= 1'b0;
        end else begin
            fault_active_reg <= fault_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers, registered so the pads never see decode glitches
    // Fault roles override direction bits without changing them, so
    // clearing a role hands the pin back to its stored direction
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pin_out_reg <= '0;
            pin_oe_reg  <= '0;
        end else begin
            pin_out_reg <= pin_level_reg;
            pin_oe_reg  <= pin_dir_reg;
            if (fault_in_en) begin
                pin_oe_reg[FAULT_IN_PIN] <= 1'b0;
            end
            if (fault_out_en) begin
                pin_oe_reg[FAULT_OUT_PIN]  <= 1'b1;
                pin_out_reg[FAULT_OUT_PIN] <= fault_next ? FAULT_PIN_ACTIVE
                                                         : ~FAULT_PIN_ACTIVE;
            end
        end
    end
    assign o_pin_out      = pin_out_reg;
    assign o_pin_oe       = pin_oe_reg;
    assign o_fault_active = fault_active_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Read path; input bits show the pin, output bits the stored value
    // Input bits lag the pin by the two synchroniser stages
    assign level_view = (pin_sync_reg & ~pin_dir_reg) | (pin_level_reg & pin_dir_reg);

    always_comb begin
        rd_value = '0;
        if (sel_dir) begin
            rd_value = pin_dir_reg;
        end else if (sel_level) begin
            rd_value = level_view;
        end else if (sel_fsrc) begin
            rd_value = fault_source_reg;
        end else if (sel_fpin) begin
            rd_value = fault_pin_reg;
            rd_value[FPIN_IN_STATUS_BIT] = fault_in_en & fault_in_latch_reg;
        end else if (sel_cmb) begin
            rd_value = cm_buffer_reg;
        end
    end

    // Read data captured in the setup phase, held through the access phase
    // Early capture gives the read mux a full cycle and keeps the
    // data steady while the master samples it
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            prdata_reg <= '0;
        end else if (setup_phase && !i_apb_req.pwrite) begin
            prdata_reg <= {{(DATA_W-REG_W){1'b0}}, rd_value};
        end
    end
    assign o_prdata = prdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Mid-level buffer controls, straight from the register
    // The ratio is passed on even while the fixed level is chosen
    assign o_midlevel_buffer_off = cm_buffer_reg[CMB_OFF_BIT];
    assign o_midlevel_ratio_sel  = cm_buffer_reg[CMB_RATIO_LSB +: CMB_RATIO_W];
    assign o_midlevel_source_sel = cm_buffer_reg[CMB_SOURCE_BIT];

    // Decoded fraction; reserved and unlisted codes give half scale
    // Registered to keep the decode off the path to the analog trim
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_midlevel_numerator <= RATIO_HALF;
        end else begin
            o_midlevel_numerator <= ratio_num(cm_buffer_reg[CMB_RATIO_LSB +: CMB_RATIO_W]);
        end
    end

endmodule

`default_nettype wire

// *** test/gpio_fault_partner.sv ***
`timescale 1ns/100ps
`default_nettype none

module gpio_fault_partner (
    input  wire logic [7:0]                 i_pin_out,
    input  wire logic [7:0]                 i_pin_oe,
    input  wire logic [7:0]                 i_ext_level,
    input  wire gpio_fault_pkg::fault_src_s i_raw_fault,
    input  wire logic                       i_diag_en,
    output logic [7:0]                      o_pin_level,
    output gpio_fault_pkg::fault_src_s      o_fault_src
);
    ////////////////////////////////////////////////////////////////////////////
    // Wire level: the block wins where it drives, else the neighbour
    assign o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_level);
    // Sources stay silent until the host enables their diagnostics
    assign o_fault_src = i_diag_en ? i_raw_fault : '0;
endmodule

`default_nettype wire

// *** test/gpio_fault_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none

module gpio_fault_monitor #(
    parameter int PIN_N = 8
) (
    input wire logic                       i_clk,
    input wire logic                       i_reset,
    input wire logic                       i_psel,
    input wire logic                       i_penable,
    input wire gpio_fault_pkg::apb_req_s   i_apb_req,
    input wire logic                       o_pready,
    input wire logic                       o_pslverr,
    input wire logic [31:0]                o_prdata,
    input wire logic [PIN_N-1:0]           i_pin_in,
    input wire logic [PIN_N-1:0]           o_pin_out,
    input wire logic [PIN_N-1:0]           o_pin_oe,
    input wire gpio_fault_pkg::fault_src_s i_fault_src,
    input wire logic                       o_fault_active,
    input wire logic                       o_midlevel_buffer_off,
    input wire logic [4:0]                 o_midlevel_ratio_sel,
    input wire logic                       o_midlevel_source_sel,
    input wire logic [4:0]                 o_midlevel_numerator
);
    import gpio_fault_pkg::*;
    logic [7:0] fsrc_sh;
    logic [7:0] fpin_sh;
    logic       acc;
    logic       comb;

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    ////////////////////////////////////////////////////////////////////////////
    // Shadows of the fault registers, so source routing can be judged
    assign acc = i_psel && i_penable && i_apb_req.pwrite && i_apb_req.pstrb[0];
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            fsrc_sh <= 8'h00;
            fpin_sh <= 8'h00;
        end else if (acc && i_apb_req.paddr == 12'h088) begin
            fsrc_sh <= i_apb_req.pwdata[7:0];
        end else if (acc && i_apb_req.paddr == 12'h08C) begin
            fpin_sh <= i_apb_req.pwdata[7:0];
        end
    end
    // Selected sources, before the output register
    assign comb = (fsrc_sh[5] & i_fault_src.overrange) | (fsrc_sh[4] & |i_fault_src.internal)
                | (fsrc_sh[3] & |i_fault_src.serial);

    function automatic logic [4:0] frac(input logic [4:0] c);
        if (c < 5'h02 || c > 5'h13) return 5'h0A;
        if (c < 5'h0B) return 5'h15 - c;
        return 5'h14 - c;
    endfunction

    sequence s_wr(logic [11:0] a);
        acc && i_apb_req.paddr == a;
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    a_fault_sources: assert property (!$past(fpin_sh[1]) |-> o_fault_active == $past(comb))
        else $error("fault output does not follow selected sources");
    a_fault_pin7: assert property ($past(fpin_sh[0]) |-> o_pin_oe[7] && o_pin_out[7] == !o_fault_active)
        else $error("pin 7 not carrying the fault");
    a_fault_in6: assert property ($past(fpin_sh[1]) |-> !o_pin_oe[6])
        else $error("pin 6 driven while a fault input");
    a_fault_chain: assert property ($past(i_pin_in[6], 3) && $past(fpin_sh[1]) |-> o_fault_active)
        else $error("fault input not chained to the output");
    a_dir_write: assert property (s_wr(12'h080) |=> ##1 o_pin_oe[5:0] == $past(i_apb_req.pwdata[5:0], 2))
        else $error("drive enables differ from direction write");
    a_level_write: assert property (s_wr(12'h084) |=> ##1
        ((o_pin_out ^ $past(i_apb_req.pwdata[7:0], 2)) & o_pin_oe & 8'h3F) == 8'h00)
        else $error("output level differs from level write");
    a_buffer_fields: assert property (s_wr(12'h090) |=>
        {o_midlevel_buffer_off, o_midlevel_ratio_sel, o_midlevel_source_sel} == $past(i_apb_req.pwdata[6:0]))
        else $error("buffer outputs differ from write");
    a_ratio_decode: assert property (o_midlevel_numerator == frac($past(o_midlevel_ratio_sel)))
        else $error("ratio numerator wrong");
    a_upper_zero: assert property (o_prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_err_unmapped: assert property (i_psel && i_penable |-> o_pready && o_pslverr == (
        i_apb_req.paddr[1:0] != 2'b00
        || i_apb_req.paddr[11:2] < 10'h020 || i_apb_req.paddr[11:2] > 10'h024))
        else $error("error response wrong for address");
endmodule

`default_nettype wire

// *** test/gpio_and_fault_pin_control_bench.sv ***
`timescale 1ns/100ps
`default_nettype none

module gpio_and_fault_pin_control_bench;
    import gpio_fault_pkg::*;
    logic        i_clk;
    logic        i_reset;
    logic        i_psel;
    logic        i_penable;
    apb_req_s    req;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [7:0]  pin_level;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    logic [7:0]  ext;
    fault_src_s  raw;
    fault_src_s  fsrc;
    logic        diag_en;
    logic        fault;
    logic        buf_off;
    logic [4:0]  ratio;
    logic        src_sel;
    logic [4:0]  num;
    logic [7:0]  dir;
    logic [7:0]  lev;
    logic [7:0]  d;
    logic [31:0] seed;
    logic [32:0] exp_q[$];
    int          error_cnt;
    int          samples_checked;
    logic [7:0]  regs[5] = '{IDX_PIN_DIR, IDX_PIN_LEVEL, IDX_FAULT_SOURCE, IDX_FAULT_PIN_CONFIG, IDX_CM_BUFFER_CONFIG};
    logic [7:0]  msk[5] = '{8'h00, 8'h00, FSRC_WMASK, FPIN_WMASK, CMB_WMASK};
    fault_src_s  srcs[3] = '{'{1'b1, 5'h00, 4'h0}, '{1'b0, 5'h04, 4'h0}, '{1'b0, 5'h00, 4'h8}};
    // Numerator over twenty per ratio code; reserved and unlisted codes give half
    logic [4:0]  frac_tab[32] = '{2: 5'h13, 3: 5'h12, 4: 5'h11, 5: 5'h10, 6: 5'h0F, 7: 5'h0E, 8: 5'h0D, 9: 5'h0C,
        10: 5'h0B, 11: 5'h09, 12: 5'h08, 13: 5'h07, 14: 5'h06, 15: 5'h05, 16: 5'h04, 17: 5'h03, 18: 5'h02,
        19: 5'h01, default: 5'h0A};

    gpio_and_fault_pin_control #(.PIN_N(8)) gpio_and_fault_pin_control_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
        .i_apb_req(req), .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
        .i_pin_in(pin_level), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_fault_src(fsrc),
        .o_fault_active(fault), .o_midlevel_buffer_off(buf_off), .o_midlevel_ratio_sel(ratio),
        .o_midlevel_source_sel(src_sel), .o_midlevel_numerator(num));
    gpio_fault_partner gpio_fault_partner_i (
        .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext_level(ext),
        .i_raw_fault(raw), .i_diag_en(diag_en), .o_pin_level(pin_level), .o_fault_src(fsrc));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    function automatic logic [31:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction

    task automatic check(input string nm, input logic [32:0] got, input logic [32:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // One APB transfer; a read leaves its expected {error, data} in the queue
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd, input logic [3:0] s,
                       input logic [32:0] e);
        int n;
        n = 0;
        if (!w) exp_q.push_back(e);
        req <= '{a, w, wd, s};
        i_psel <= 1'b1;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            wrap_up();
        end
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask

    // Reads are judged as their access phase completes
    always @(posedge i_clk) begin
        if (i_psel && i_penable && pready === 1'b1 && !req.pwrite) check("read", {pslverr, prdata}, exp_q.pop_front());
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_reset = 1'b1;
        i_psel = 1'b0;
        i_penable = 1'b0;
        req = '0;
        ext = 8'h00;
        raw = '0;
        diag_en = 1'b0;
        seed = 32'h00007BB8;
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        // Reset values, unmapped place, reserved bits
        for (int k = 0; k < 5; k++) apb(ad(regs[k]), 1'b0, 32'h0, 4'hF, 33'h0);
        apb(12'h0A0, 1'b0, 32'h0, 4'hF, {1'b1, 32'h0});
        for (int k = 2; k < 5; k++) begin
            apb(ad(regs[k]), 1'b1, 32'hFFFFFFFF, 4'hF, 33'h0);
            apb(ad(regs[k]), 1'b0, 32'h0, 4'hF, {25'h0, msk[k]});
            apb(ad(regs[k]), 1'b1, 32'h0, 4'hF, 33'h0);
        end
        $display("test reset done");
        // Random directions, levels and neighbour drive; a write without strobe is ignored
        repeat (4) begin
            dir = 8'(nxt());
            lev = 8'(nxt());
            ext <= 8'(nxt());
            apb(ad(IDX_PIN_DIR), 1'b1, {24'h0, dir}, 4'hF, 33'h0);
            apb(ad(IDX_PIN_LEVEL), 1'b1, {24'h0, lev}, 4'hF, 33'h0);
            apb(ad(IDX_PIN_LEVEL), 1'b1, {24'h0, ~lev}, 4'hE, 33'h0);
            repeat (3) @(posedge i_clk);
            check("oe", {25'h0, pin_oe}, {25'h0, dir});
            check("out", {25'h0, pin_out & dir}, {25'h0, lev & dir});
            apb(ad(IDX_PIN_LEVEL), 1'b0, 32'h0, 4'hF, {25'h0, (lev & dir) | (ext & ~dir)});
        end
        $display("test pins done");
        // Each source alone: blocked by the other enables, passed by its own
        ext <= 8'h00;
        diag_en <= 1'b1;
        apb(ad(IDX_FAULT_PIN_CONFIG), 1'b1, 32'h1, 4'hF, 33'h0);
        for (int k = 0; k < 3; k++) begin
            raw <= srcs[k];
            apb(ad(IDX_FAULT_SOURCE), 1'b1, {24'h0, 8'h38 ^ (8'h20 >> k)}, 4'hF, 33'h0);
            repeat (2) @(posedge i_clk);
            check("fault off", {32'h0, fault}, 33'h0);
            apb(ad(IDX_FAULT_SOURCE), 1'b1, {24'h0, 8'h20 >> k}, 4'hF, 33'h0);
            repeat (2) @(posedge i_clk);
            check("fault on", {32'h0, fault}, 33'h1);
            check("pin7", {31'h0, pin_oe[7], pin_out[7]}, 33'h2);
        end
        raw <= '0;
        apb(ad(IDX_FAULT_SOURCE), 1'b1, 32'h0, 4'hF, 33'h0);
        $display("test sources done");
        // Upstream fault on pin 6, latched until read
        apb(ad(IDX_FAULT_PIN_CONFIG), 1'b1, 32'h3, 4'hF, 33'h0);
        ext <= 8'h40;
        repeat (5) @(posedge i_clk);
        check("fault in", {30'h0, fault, pin_oe[6], pin_out[7]}, 33'h4);
        ext <= 8'h00;
        repeat (5) @(posedge i_clk);
        apb(ad(IDX_FAULT_PIN_CONFIG), 1'b0, 32'h0, 4'hF, 33'h7);
        apb(ad(IDX_FAULT_PIN_CONFIG), 1'b0, 32'h0, 4'hF, 33'h3);
        apb(ad(IDX_FAULT_PIN_CONFIG), 1'b1, 32'h0, 4'hF, 33'h0);
        $display("test fault input done");
        // Every ratio code, with the reserved top bit set
        for (int k = 0; k < 32; k++) begin
            d = {1'b1, k[0], k[4:0], k[1]};
            apb(ad(IDX_CM_BUFFER_CONFIG), 1'b1, {24'h0, d}, 4'hF, 33'h0);
            apb(ad(IDX_CM_BUFFER_CONFIG), 1'b0, 32'h0, 4'hF, {25'h0, d & 8'h7F});
            check("buffer", {26'h0, buf_off, ratio, src_sel}, {26'h0, d[6:0]});
            check("ratio", {28'h0, num}, {28'h0, frac_tab[k]});
        end
        $display("test buffer done");
        check("queue", 33'(exp_q.size()), 33'h0);
        wrap_up();
    end
endmodule

bind gpio_and_fault_pin_control gpio_fault_monitor #(.PIN_N(PIN_N)) gpio_fault_monitor_i (.*);

`default_nettype wire
